// file: rtl/asp_regs.svh
// constants of the angle sensor serial port: offsets, fields, reset values, timing counts
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH

// clocking and sample rate
`define ASP_CLK_HZ              10000000
`define ASP_SAMPLE_HZ           1000000
`define ASP_SAMPLE_DIV          (`ASP_CLK_HZ / `ASP_SAMPLE_HZ)
// non-volatile write wait, in ms and in clock cycles
`define ASP_NVM_WAIT_MS         20
`define ASP_NVM_WAIT_CYCLES     (`ASP_NVM_WAIT_MS * (`ASP_CLK_HZ / 1000))
// host-side gaps, kept for reference by the bench
`define ASP_ANGLE_GAP_TIME_NS   150
`define ASP_REGISTER_GAP_TIME_NS 750
// frame layout
`define ASP_FRAME_BITS          16
`define ASP_ANGLE_BITS          8
`define ASP_CMD_READ            3'h2
`define ASP_CMD_WRITE           3'h4
// register addresses
`define ASP_REG_ZERO_LO         5'h00
`define ASP_REG_ZERO_HI         5'h01
`define ASP_REG_THRESH          5'h06
`define ASP_REG_DIR             5'h09
`define ASP_REG_FLAGS           5'h1b
// reset values
`define ASP_THRESH_RESET        8'h1c
`define ASP_OTHER_RESET         8'h00
// field positions
`define ASP_LOW_THR_MSB         7
`define ASP_LOW_THR_LSB         5
`define ASP_HIGH_THR_MSB        4
`define ASP_HIGH_THR_LSB        2
`define ASP_FLAG_HIGH_BIT       7
`define ASP_FLAG_LOW_BIT        6

`endif

// file: rtl/asp_pkg.sv
// types shared by the angle sensor serial port
package asp_pkg;

  // one received sixteen-bit command frame
  typedef struct packed
  {
    logic [2:0] cmd;
    logic [4:0] addr;
    logic [7:0] data;
  } asp_frame_type;

  // what the next frame shifts out
  typedef enum logic [0:0] {ASP_REPLY_ANGLE, ASP_REPLY_REG} asp_reply_type;

endpackage

// file: rtl/asp_pair_buffer.sv
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module asp_pair_buffer
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
)
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // draining side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // whole buffer state
  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 count;
  } asp_buf_state_type;

  asp_buf_state_type state_reg;  // registered state
  asp_buf_state_type state_next; // next state
  logic              push;       // word accepted
  logic              pop;        // word delivered

  ////////////////////////////////////////////////////////////////////////////
  // honest full and empty straight from the count
  assign in_ready  = (state_reg.count != (PW+1)'(DEPTH));
  assign out_valid = (state_reg.count != '0);
  assign out_data  = state_reg.mem[state_reg.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // next state: pointers wrap at depth
  always_comb
  begin
    state_next = state_reg;
    if (push)
    begin
      state_next.mem[state_reg.wr] = in_data;
      state_next.wr = (state_reg.wr == PW'(DEPTH - 1)) ? '0 : state_reg.wr + 1'b1;
    end
    if (pop)
      state_next.rd = (state_reg.rd == PW'(DEPTH - 1)) ? '0 : state_reg.rd + 1'b1;
    if (push && !pop)
      state_next.count = state_reg.count + 1'b1;
    else if (pop && !push)
      state_next.count = state_reg.count - 1'b1;
  end

  // state register
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

endmodule
`default_nettype wire

// file: rtl/asp_serial_port.sv
// angle sensor serial slave port: link shifter, crossing, command handling, config registers
`timescale 1ns/1ps
`default_nettype none
`include "asp_regs.svh"
module asp_serial_port
  import asp_pkg::*;
#(
  parameter int NVM_WAIT_CYCLES = `ASP_NVM_WAIT_CYCLES
)
(
  // system clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // serial link pins
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output logic            miso_out,
  output logic            miso_oe,
  output logic            miso_pulldown_en,
  // front end, same clock domain
  input  wire logic [7:0] angle_raw,
  input  wire logic [2:0] field_level,
  // field flags
  output logic            field_low_flag,
  output logic            field_high_flag,
  // status
  output logic            frame_buffer_ready,
  output logic            nvm_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // link side, clocked by sclk
  // nothing here reads system-side state except the reply word, and that one
  // only through the snapshot taken as select falls

  logic        frame_rst;    // select idle or system reset clears the frame
  logic [4:0]  bit_cnt_reg;  // rising edges seen in this frame
  logic [15:0] shift_reg;    // incoming bits
  logic [15:0] rx_hold_reg;  // last complete frame, stable until the next one
  logic        done_tgl_reg; // flips once per complete frame
  logic        out_bit_reg;  // bit launched on the falling edge
  logic [15:0] tx_word_reg;  // reply word, system domain, frozen while the synchronised select is low
  logic [15:0] frame_word_reg; // reply word as taken at the select fall

  // select high holds the frame logic cleared, so a fall always starts at bit 0;
  // a frame cut short leaves nothing behind once select rises again
  assign frame_rst = cs_n || !rstn;

  // the reply word is taken once, at the select fall, so a frame never shifts
  // a mix of two words although the system side sees the fall a few clocks
  // late and may still refresh its own copy meanwhile; the one hazard left
  // is a fall within a few ns of a refresh edge, where a bit may catch either
  // word, which the host avoids by keeping its idle gap before each frame
  always_ff @(negedge cs_n or negedge rstn)
  begin
    if (!rstn)
      frame_word_reg <= 16'h0000;
    else
      frame_word_reg <= tx_word_reg;
  end

  // capture on the rising edge, msb first, count saturates past the frame
  always_ff @(posedge sclk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      bit_cnt_reg <= 5'h00;
      shift_reg   <= 16'h0000;
    end
    else
    begin
      shift_reg <= {shift_reg[14:0], mosi};
      // saturate, so clocks after bit sixteen leave the count alone
      if (bit_cnt_reg != 5'(`ASP_FRAME_BITS))
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  // the frame is handed over only at the sixteenth rising edge
  always_ff @(posedge sclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_hold_reg  <= 16'h0000;
      done_tgl_reg <= 1'b0;
    end
    else if (!cs_n && bit_cnt_reg == 5'(`ASP_FRAME_BITS - 1))
    begin
      // a frame cut short never reaches this edge and is dropped
      rx_hold_reg  <= {shift_reg[14:0], mosi};
      // only the toggle crosses over; the word beside it stays still until taken
      done_tgl_reg <= ~done_tgl_reg;
    end
  end

  // launch on the falling edge the bit that the count points at;
  // in mode 3 the first fall comes before any rise and launches bit 15
  always_ff @(negedge sclk or posedge frame_rst)
  begin
    // select idle: quiet line
    if (frame_rst)
      out_bit_reg <= 1'b0;
    // inside the frame: next bit of the snapshot, msb first
    else if (bit_cnt_reg < 5'(`ASP_FRAME_BITS))
      out_bit_reg <= frame_word_reg[4'(`ASP_FRAME_BITS - 1) - bit_cnt_reg[3:0]];
    // clocks past bit sixteen only shift zeros
    else
      out_bit_reg <= 1'b0;
  end

  // before the first rise the msb stands on the line, which serves mode 0
  // without knowing the mode; mode 3's first fall loads the same bit into out_bit_reg, which drives the line from the first rise
  assign miso_out         = (bit_cnt_reg == 5'h00) ? frame_word_reg[15] : out_bit_reg;
  // driven only inside a frame; outside it the weak pull-down holds the line
  assign miso_oe          = !cs_n;
  assign miso_pulldown_en = cs_n;

  ////////////////////////////////////////////////////////////////////////////
  // system side, clocked by clock

  // whole system-side state
  typedef struct packed
  {
    logic          cs_s1;      // select synchroniser, first stage
    logic          cs_s2;      // select synchroniser, second stage
    logic          tgl_s1;     // frame toggle, first stage
    logic          tgl_s2;     // frame toggle, second stage
    logic          tgl_seen;   // toggle value already taken
    logic [3:0]    div_cnt;    // sample rate divider
    logic [7:0]    angle;      // latest angle sample
    logic          low_flag;   // field below low threshold
    logic          high_flag;  // field above high threshold
    logic          busy;       // non-volatile write in progress
    logic [17:0]   wait_cnt;   // write wait counter
    logic [4:0]    pend_addr;  // address being written
    logic [7:0]    pend_data;  // value being written
    asp_reply_type reply_kind; // what the next frame returns
    logic [4:0]    reply_addr; // register that the next frame returns
    logic [15:0]   tx_word;    // reply word seen by the link
  } asp_state_type;

  asp_state_type state_reg;  // registered state
  asp_state_type state_next; // next state
  logic [7:0]    cfg_mem [0:31]; // configuration registers
  logic          frame_valid;    // new frame from the link
  logic          cmd_valid;      // buffered frame waiting
  logic [15:0]   cmd_word;       // buffered frame
  asp_frame_type cmd;            // buffered frame, split into fields
  logic          cmd_take;       // frame consumed this cycle
  logic          commit;         // write wait over, store value
  logic [7:0]    reg_value;      // register addressed by the reply

  // field split of the oldest buffered frame
  assign cmd = asp_frame_type'(cmd_word);

  // one new frame per toggle change; rx_hold_reg is stable by then
  assign frame_valid = (state_reg.tgl_s2 != state_reg.tgl_seen);

  // processing stalls during the write wait, so frames pile up in the buffer
  assign cmd_take = cmd_valid && !state_reg.busy;
  assign commit   = state_reg.busy && (state_reg.wait_cnt == 18'(NVM_WAIT_CYCLES - 1));

  // frames of the link queue here; a third frame while full is lost
  // the command logic may hold off during the write wait, the link never can
  asp_pair_buffer
  #(
    .WIDTH (`ASP_FRAME_BITS),
    .DEPTH (2)
  )
  u_buffer
  (
    .clock     (clock),
    .rstn      (rstn),
    .in_valid  (frame_valid),
    .in_data   (rx_hold_reg),
    .in_ready  (frame_buffer_ready),
    .out_valid (cmd_valid),
    .out_data  (cmd_word),
    .out_ready (!state_reg.busy)
  );

  // register readback; the flags register is built from live state
  always_comb
  begin
    // addresses never written, the flags address aside, read back their reset value
    reg_value = cfg_mem[state_reg.reply_addr];
    if (state_reg.reply_addr == `ASP_REG_FLAGS)
    begin
      reg_value = 8'h00;
      reg_value[`ASP_FLAG_HIGH_BIT] = state_reg.high_flag;
      reg_value[`ASP_FLAG_LOW_BIT]  = state_reg.low_flag;
    end
  end

  // next state of the system side
  always_comb
  begin
    state_next = state_reg;
    // synchronisers: first stage read only by the second
    state_next.cs_s1  = cs_n;
    state_next.cs_s2  = state_reg.cs_s1;
    state_next.tgl_s1 = done_tgl_reg;
    state_next.tgl_s2 = state_reg.tgl_s1;
    // remembering the toggle turns each change into a one-cycle strobe
    state_next.tgl_seen = state_reg.tgl_s2;

    // sample the front-end angle once per microsecond; the field level is compared every cycle
    // between samples the host reads the previous one, at most a microsecond old
    if (state_reg.div_cnt == 4'(`ASP_SAMPLE_DIV - 1))
    begin
      state_next.div_cnt = 4'h0;
      state_next.angle   = angle_raw;
    end
    else
      state_next.div_cnt = state_reg.div_cnt + 4'h1;

    // field flags against the programmed thresholds
    // registered, so the flag pins never glitch while the level input settles
    state_next.low_flag  = field_level < cfg_mem[`ASP_REG_THRESH][`ASP_LOW_THR_MSB:`ASP_LOW_THR_LSB];
    state_next.high_flag = field_level > cfg_mem[`ASP_REG_THRESH][`ASP_HIGH_THR_MSB:`ASP_HIGH_THR_LSB];

    // write wait: the register keeps its old value until the end
    // commit falls on the last counted cycle, so busy lasts exactly the wait
    if (state_reg.busy)
    begin
      state_next.wait_cnt = state_reg.wait_cnt + 18'h00001;
      if (commit)
      begin
        state_next.busy       = 1'b0;
        state_next.reply_kind = ASP_REPLY_REG;
        state_next.reply_addr = state_reg.pend_addr;
      end
    end

    // command decode
    // nothing is taken during the wait; the buffer holds up to two frames
    if (cmd_take)
    begin
      if (cmd.cmd == `ASP_CMD_READ)
      begin
        state_next.reply_kind = ASP_REPLY_REG;
        state_next.reply_addr = cmd.addr;
      end
      else if (cmd.cmd == `ASP_CMD_WRITE)
      begin
        // a readout during the wait returns the previous value
        state_next.busy       = 1'b1;
        state_next.wait_cnt   = 18'h00000;
        state_next.pend_addr  = cmd.addr;
        state_next.pend_data  = cmd.data;
        state_next.reply_kind = ASP_REPLY_REG;
        state_next.reply_addr = cmd.addr;
      end
      else
        // any other frame, dummy frames included, asks for the angle
        state_next.reply_kind = ASP_REPLY_ANGLE;
    end

    // reply word is refreshed while select idles; the link takes its own
    // snapshot of it at the next select fall
    if (state_reg.cs_s2)
    begin
      if (state_reg.reply_kind == ASP_REPLY_REG)
        state_next.tx_word = {reg_value, 8'h00};
      else
        state_next.tx_word = {state_reg.angle, 8'h00};
    end
  end

  // system-side state register
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      // select starts idle, so the reply word loads straight after reset
      state_reg            <= '0;
      state_reg.cs_s1      <= 1'b1;
      state_reg.cs_s2      <= 1'b1;
      state_reg.reply_kind <= ASP_REPLY_ANGLE;
    end
    else
      state_reg <= state_next;
  end

  // configuration registers; the flags register is read-only
  // a write aimed at the flags address is dropped, though its wait still runs
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 32; i++)
        cfg_mem[i] <= (5'(i) == `ASP_REG_THRESH) ? `ASP_THRESH_RESET : `ASP_OTHER_RESET;
    end
    else if (commit && state_reg.pend_addr != `ASP_REG_FLAGS)
      cfg_mem[state_reg.pend_addr] <= state_reg.pend_data;
  end

  // outputs from flip-flops
  assign tx_word_reg     = state_reg.tx_word;
  assign field_low_flag  = state_reg.low_flag;
  assign field_high_flag = state_reg.high_flag;
  assign nvm_busy        = state_reg.busy;

endmodule
`default_nettype wire

// file: tb/asp_serial_port_assertions.sv
// concurrent checks on the angle sensor serial port pins
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port_checker
#(
  parameter int NVM_WAIT_CYCLES = 20
)
(
  // clocks and reset
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       sclk,
  // link pins
  input wire logic       cs_n,
  input wire logic       miso_out,
  input wire logic       miso_oe,
  input wire logic       miso_pulldown_en,
  // field and status
  input wire logic [2:0] field_level,
  input wire logic       field_low_flag,
  input wire logic       field_high_flag,
  input wire logic       frame_buffer_ready,
  input wire logic       nvm_busy
);
  logic [4:0] rise_cnt; // clock rises seen in this frame
  logic [1:0] up_cnt;   // cycles since reset, saturating
  int         busy_len; // cycles the write wait has lasted
  ////////////////////////
  // select high clears at once, as a frame may end at any time
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      rise_cnt <= 5'h00;
    else if (rise_cnt != 5'h1f)
      rise_cnt <= rise_cnt + 5'h01;
  end
  // keeps the flag checks off the edges just after reset
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      up_cnt   <= 2'h0;
      busy_len <= 0;
    end
    else
    begin
      if (up_cnt != 2'h3)
        up_cnt <= up_cnt + 2'h1;
      busy_len <= nvm_busy ? busy_len + 1 : 0;
    end
  end
  ////////////////////////
  oe_follows_select_a: assert property (@(posedge clock) disable iff (!rstn) miso_oe == !cs_n)
    else $error("data out enable not tied to select");
  pulldown_when_idle_a: assert property (@(posedge clock) disable iff (!rstn)
    miso_pulldown_en == cs_n && !(miso_oe && miso_pulldown_en))
    else $error("pull-down not matching a floating line");
  low_byte_zero_a: assert property (@(posedge sclk) disable iff (!rstn)
    (!cs_n && rise_cnt >= 5'h08 && rise_cnt <= 5'h0f) |-> !miso_out)
    else $error("lower reply byte not zero");
  busy_length_a: assert property (@(posedge clock) disable iff (!rstn)
    $fell(nvm_busy) |-> busy_len == NVM_WAIT_CYCLES)
    else $error("write wait of wrong length");
  buffer_full_busy_a: assert property (@(posedge clock) disable iff (!rstn)
    $fell(frame_buffer_ready) |-> nvm_busy)
    else $error("frame buffer filled outside a write wait");
  reset_quiet_a: assert property (@(posedge clock)
    $rose(rstn) |-> !nvm_busy && frame_buffer_ready && !field_low_flag && !field_high_flag)
    else $error("outputs not idle after reset");
  low_flag_cause_a: assert property (@(posedge clock) disable iff (!rstn)
    (up_cnt == 2'h3 && $changed(field_low_flag)) |-> $past(field_level) != $past(field_level, 2)
    || $past(field_level, 2) != $past(field_level, 3) || $past(nvm_busy, 2) || $past(nvm_busy, 3))
    else $error("low flag moved with no cause");
  high_flag_cause_a: assert property (@(posedge clock) disable iff (!rstn)
    (up_cnt == 2'h3 && $changed(field_high_flag)) |-> $past(field_level) != $past(field_level, 2)
    || $past(field_level, 2) != $past(field_level, 3) || $past(nvm_busy, 2) || $past(nvm_busy, 3))
    else $error("high flag moved with no cause");
  // main scenarios reached
  cover property (@(posedge clock) $rose(nvm_busy));
  cover property (@(posedge clock) $fell(frame_buffer_ready));
  cover property (@(posedge clock) $rose(field_high_flag));
endmodule
bind asp_serial_port asp_serial_port_checker #(.NVM_WAIT_CYCLES(NVM_WAIT_CYCLES)) chk
(
  .clock(clock), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .miso_out(miso_out), .miso_oe(miso_oe),
  .miso_pulldown_en(miso_pulldown_en), .field_level(field_level), .field_low_flag(field_low_flag),
  .field_high_flag(field_high_flag), .frame_buffer_ready(frame_buffer_ready), .nvm_busy(nvm_busy)
);
`default_nettype wire

// file: tb/asp_host_model.sv
// host model: serial master driving select, clock and data in
`timescale 1ns/1ps
`default_nettype none
module asp_host_model
(
  // link pins
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  ////////////////////////
  // idle select, clock still between frames
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // one frame; fewer than sixteen bits only to cut a frame short
  task automatic xfer(input logic mode3, input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    sclk = mode3;
    #200;
    cs_n = 1'b0;
    #100;
    for (int i = 0; i < nbits; i++)
    begin
      sclk = 1'b0;
      mosi = tx[15 - i];
      #24;
      sclk = 1'b1;
      rx[15 - i] = miso;
      #24;
    end
    sclk = mode3;
    #30;
    cs_n = 1'b1;
    mosi = ~mosi; // released line shows no stale value
    #800;
  endtask
endmodule
`default_nettype wire

// file: tb/asp_serial_port_tb_top.sv
// testbench for the angle sensor serial port
`timescale 1ns/1ps
`default_nettype none
`include "asp_regs.svh"
`define CHECK(name, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("Error %s expected %h seen %h", name, exp, got); \
    end \
  end
module asp_serial_port_tb_top;
  localparam int         NVM_WAIT = 60;                  // shortened write wait
  localparam logic [2:0] LVL [3]  = '{3'h2, 3'h4, 3'h6}; // field levels tried
  logic        clock, rstn, sclk, cs_n, mosi, miso_out, miso_oe, miso_pd, miso_line;
  logic        low_flag, high_flag, buf_ready, nvm_busy;
  logic [7:0]  angle_raw;
  logic [2:0]  field_level;
  logic [15:0] rx;
  int          num_errors = 0;
  int          samples_checked = 0;
  ////////////////////////
  // weak pull-down holds the line low while the port floats it; without it the line shows junk
  assign miso_line = miso_oe ? miso_out : (miso_pd ? 1'b0 : ~miso_out);
  asp_serial_port #(.NVM_WAIT_CYCLES(NVM_WAIT)) DUT
  (
    .clock(clock), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso_out(miso_out),
    .miso_oe(miso_oe), .miso_pulldown_en(miso_pd), .angle_raw(angle_raw), .field_level(field_level),
    .field_low_flag(low_flag), .field_high_flag(high_flag), .frame_buffer_ready(buf_ready),
    .nvm_busy(nvm_busy)
  );
  asp_host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_line));
  // system clock
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  ////////////////////////
  task automatic test_done;
    $display("Checked %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // waits out the write wait and any queued frames
  task automatic wait_idle;
    int n;
    n = 0;
    while ((nvm_busy !== 1'b0 || buf_ready !== 1'b1) && n < 1000)
    begin
      @(posedge clock);
      n++;
    end
    if (n == 1000)
    begin
      num_errors++;
      test_done;
    end
    else
      repeat (10) @(posedge clock);
  endtask
  // register read: command frame, then answer frame in the other mode
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] v);
    host.xfer(1'b0, {`ASP_CMD_READ, a, 8'h00}, 16, v);
    host.xfer(1'b1, 16'h0000, 16, v);
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    host.xfer(1'b0, {`ASP_CMD_WRITE, a, d}, 16, rx);
  endtask
  ////////////////////////
  initial
  begin
    rstn = 1'b0;
    angle_raw = 8'ha5;
    field_level = 3'h4;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    `CHECK("reset outputs", 4'h4, {nvm_busy, buf_ready, low_flag, high_flag})
    // angle reads in mode 0 then mode 3
    for (int m = 0; m < 2; m++)
    begin
      @(posedge clock);
      angle_raw <= m[0] ? 8'h3c : 8'ha5;
      host.xfer(m[0], 16'h0000, 16, rx);
      host.xfer(m[0], 16'h0000, 16, rx);
      `CHECK("angle", {angle_raw, 8'h00}, rx)
    end
    rd_reg(`ASP_REG_THRESH, rx);
    `CHECK("threshold default", {`ASP_THRESH_RESET, 8'h00}, rx)
    wr_reg(`ASP_REG_THRESH, 8'h74);
    wait_idle;
    host.xfer(1'b0, 16'h0000, 16, rx);
    `CHECK("threshold echo", 16'h7400, rx)
    // low threshold now 3, high threshold 5
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clock);
      field_level <= LVL[i];
      repeat (4) @(posedge clock);
      `CHECK("low flag", LVL[i] < 3'h3, low_flag)
      `CHECK("high flag", LVL[i] > 3'h5, high_flag)
    end
    rd_reg(`ASP_REG_FLAGS, rx);
    `CHECK("flag register", 16'h8000, rx)
    // a cut-short read command is dropped
    host.xfer(1'b0, {`ASP_CMD_READ, `ASP_REG_THRESH, 8'h00}, 8, rx);
    host.xfer(1'b0, 16'h0000, 16, rx);
    `CHECK("angle after partial", {angle_raw, 8'h00}, rx)
    // frames sent during the write wait queue up and see the old value
    wr_reg(`ASP_REG_DIR, 8'h80);
    host.xfer(1'b1, 16'h0000, 16, rx);
    `CHECK("old value in wait", 16'h0000, rx)
    host.xfer(1'b1, 16'h0000, 16, rx);
    `CHECK("buffer full", 1'b0, buf_ready)
    wait_idle;
    rd_reg(`ASP_REG_DIR, rx);
    `CHECK("direction stored", 16'h8000, rx)
    test_done;
  end
endmodule
`default_nettype wire
